// ===== logic/xse_pkg.sv
// package: constants for extended state enable gating
package xse_pkg;
  // feature query leaf 1 ecx bit positions
  localparam int XSE_L1_SAVE_SUP_BIT = 26;
  localparam int XSE_L1_OS_MGMT_BIT = 27;
  // control_reg_four bit positions
  localparam int XSE_CR4_OS_MGMT_BIT = 18;
  localparam int XSE_CR4_SIMD_EXC_BIT = 10;
  localparam int XSE_CR4_LEG_SIMD_BIT = 9;
  // state_component_enable_reg bit positions
  localparam int XSE_SC_LEGACY_FP = 0;
  localparam int XSE_SC_NARROW = 1;
  localparam int XSE_SC_WIDE = 2;
  localparam int XSE_SC_RSVD_LO = 3;
  // reset values
  localparam logic [63:0] XSE_SC_RESET = 64'h0000_0000_0000_0001;
  localparam logic [31:0] XSE_CR4_RESET = 32'h0000_0000;
  // supported component vector and save-area sizes in bytes
  localparam logic [63:0] XSE_SUPPORT_DEF = 64'h0000_0000_0000_0007;
  localparam logic [31:0] XSE_LEGACY_AREA_BYTES = 32'h0000_0200;
  localparam logic [31:0] XSE_HEADER_BYTES = 32'h0000_0040;
  localparam logic [31:0] XSE_WIDE_AREA_BYTES = 32'h0000_0100;
  // fault codes
  typedef enum logic [1:0] {XSE_FLT_NONE, XSE_FLT_UD, XSE_FLT_GP} xse_fault_t;
  // instruction classes presented for gating
  typedef enum logic [2:0] {
    XSE_OP_NONE, XSE_OP_WRITE_EN, XSE_OP_READ_EN, XSE_OP_SAVE_RESTORE,
    XSE_OP_WIDE_VEC, XSE_OP_NARROW_SIMD, XSE_OP_EXT_STATE
  } xse_op_t;
endpackage : xse_pkg

// ===== logic/xse_size_calc.sv
// module: save buffer size from an enable mask
`timescale 1ns/1ps
module xse_size_calc
  import xse_pkg::*;
(
  input wire logic [63:0] mask,
  output logic [31:0] size_bytes
);
  // header is always counted alongside the legacy area
  assign size_bytes = XSE_LEGACY_AREA_BYTES + XSE_HEADER_BYTES +
                      (mask[XSE_SC_WIDE] ? XSE_WIDE_AREA_BYTES : 32'h0000_0000);
endmodule : xse_size_calc

// ===== logic/xse_gate.sv
// module: extended state enable registers, feature query and instruction gating
`timescale 1ns/1ps
module xse_gate
  import xse_pkg::*;
#(
  parameter logic SAVE_SUPPORTED = 1'b1,
  parameter logic [63:0] SUPPORT_VEC = XSE_SUPPORT_DEF,
  parameter int EXT_COMPONENTS = 3
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  // control_reg_four write port
  input wire logic cr4_wr,
  input wire logic [31:0] cr4_wdata,
  output logic [31:0] cr4_rdata,
  // instruction issue
  input wire logic op_valid,
  input wire xse_op_t op_kind,
  input wire logic [1:0] op_cpl,
  input wire logic [63:0] op_mask,
  input wire logic [5:0] op_comp,
  input wire logic op_feat_ok,
  input wire logic op_simd_exc,
  // instruction outcome
  output logic res_valid,
  output xse_fault_t res_fault,
  output logic [63:0] res_data,
  output logic res_simd_exc,
  // feature query
  input wire logic fq_valid,
  input wire logic [31:0] fq_leaf,
  input wire logic [31:0] fq_sub,
  output logic fq_done,
  output logic [31:0] fq_eax,
  output logic [31:0] fq_ecx,
  output logic [31:0] fq_edx,
  // live state
  output logic [63:0] sc_enable
);
  // =========================================
  // registers
  logic [63:0] sc_reg;
  logic [63:0] sc_next;
  logic [31:0] cr4_reg;
  logic [31:0] cr4_next;
  logic [31:0] size_now;

  // =========================================
  // decode
  wire os_mgmt = cr4_reg[XSE_CR4_OS_MGMT_BIT];
  wire simd_exc_en = cr4_reg[XSE_CR4_SIMD_EXC_BIT];
  wire leg_simd_en = cr4_reg[XSE_CR4_LEG_SIMD_BIT];
  wire wide_on = os_mgmt && sc_reg[XSE_SC_WIDE] && sc_reg[XSE_SC_NARROW];
  wire is_wr = op_valid && (op_kind == XSE_OP_WRITE_EN);
  wire is_rd = op_valid && (op_kind == XSE_OP_READ_EN);
  wire bad_b0 = !op_mask[XSE_SC_LEGACY_FP];
  wire bad_21 = op_mask[XSE_SC_WIDE:XSE_SC_NARROW] == 2'b10;
  wire bad_sup = |(op_mask & ~SUPPORT_VEC);
  wire wr_gp = (op_cpl != 2'b00) || bad_b0 || bad_21 || bad_sup;
  wire comp_ok = (op_comp < 6'(EXT_COMPONENTS)) && sc_reg[op_comp] && os_mgmt && op_feat_ok;
  wire sc_wr_ok = is_wr && os_mgmt && !wr_gp;

  // =========================================
  // gating
  xse_fault_t fault_w;
  always_comb begin
    fault_w = XSE_FLT_NONE;
    case (op_kind)
      XSE_OP_WRITE_EN: fault_w = !os_mgmt ? XSE_FLT_UD : (wr_gp ? XSE_FLT_GP : XSE_FLT_NONE);
      XSE_OP_READ_EN: fault_w = !os_mgmt ? XSE_FLT_UD : XSE_FLT_NONE;
      XSE_OP_SAVE_RESTORE: fault_w = !os_mgmt ? XSE_FLT_UD : XSE_FLT_NONE;
      XSE_OP_WIDE_VEC: fault_w = wide_on ? XSE_FLT_NONE : XSE_FLT_UD;
      XSE_OP_NARROW_SIMD: fault_w = leg_simd_en ? XSE_FLT_NONE : XSE_FLT_UD;
      XSE_OP_EXT_STATE: fault_w = (op_comp <= 6'd1) ? XSE_FLT_NONE :
                                  (comp_ok ? XSE_FLT_NONE : XSE_FLT_UD);
      default: fault_w = XSE_FLT_NONE;
    endcase
  end
  wire simd_class = (op_kind == XSE_OP_WIDE_VEC) || (op_kind == XSE_OP_NARROW_SIMD);
  wire simd_exc_w = op_valid && simd_class && (fault_w == XSE_FLT_NONE) && op_simd_exc && simd_exc_en;

  // =========================================
  // register updates
  assign sc_next = sc_wr_ok ? op_mask : sc_reg;
  assign cr4_next = cr4_wr ?
    {cr4_wdata[31:19], cr4_wdata[XSE_CR4_OS_MGMT_BIT] & SAVE_SUPPORTED, cr4_wdata[17:0]} : cr4_reg;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sc_reg <= XSE_SC_RESET;
      cr4_reg <= XSE_CR4_RESET;
    end else begin
      sc_reg <= sc_next;
      cr4_reg <= cr4_next;
    end
  end

  // =========================================
  // feature query
  xse_size_calc u_size (
    .mask(sc_reg),
    .size_bytes(size_now)
  );
  wire leaf1 = fq_leaf == 32'h0000_0001;
  wire leafd = (fq_leaf == 32'h0000_000d) && (fq_sub == 32'h0000_0000);
  wire [31:0] l1_ecx = (32'(SAVE_SUPPORTED) << XSE_L1_SAVE_SUP_BIT) |
                       (32'(os_mgmt) << XSE_L1_OS_MGMT_BIT);
  wire [31:0] eax_w = leafd ? SUPPORT_VEC[31:0] : 32'h0000_0000;
  wire [31:0] edx_w = leafd ? SUPPORT_VEC[63:32] : 32'h0000_0000;
  wire [31:0] ecx_w = leaf1 ? l1_ecx : (leafd ? size_now : 32'h0000_0000);

  // =========================================
  // outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      res_valid <= 1'b0;
      res_fault <= XSE_FLT_NONE;
      res_data <= 64'h0000_0000_0000_0000;
      res_simd_exc <= 1'b0;
      fq_done <= 1'b0;
      fq_eax <= 32'h0000_0000;
      fq_ecx <= 32'h0000_0000;
      fq_edx <= 32'h0000_0000;
      cr4_rdata <= XSE_CR4_RESET;
      sc_enable <= XSE_SC_RESET;
    end else begin
      res_valid <= op_valid;
      res_fault <= op_valid ? fault_w : XSE_FLT_NONE;
      res_data <= (is_rd && os_mgmt) ? sc_reg : 64'h0000_0000_0000_0000;
      res_simd_exc <= simd_exc_w;
      fq_done <= fq_valid;
      fq_eax <= fq_valid ? eax_w : 32'h0000_0000;
      fq_ecx <= fq_valid ? ecx_w : 32'h0000_0000;
      fq_edx <= fq_valid ? edx_w : 32'h0000_0000;
      cr4_rdata <= cr4_next;
      sc_enable <= sc_next;
    end
  end

  // =========================================
  // assertions
  sequence wr_attempt_s;
    is_wr && os_mgmt && wr_gp;
  endsequence
  sequence gp_answer_s;
    res_valid && (res_fault == XSE_FLT_GP);
  endsequence
  wr_gp_fault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_attempt_s |=> gp_answer_s) else $error("bad write mask not faulted");
  bit0_kept_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    sc_reg[XSE_SC_LEGACY_FP]) else $error("legacy bit cleared");
  mirror_bit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    fq_valid && leaf1 |=> fq_ecx[XSE_L1_OS_MGMT_BIT] == $past(os_mgmt)) else $error("mirror wrong");
  no_mgmt_ud_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_READ_EN) && !os_mgmt |=> res_fault == XSE_FLT_UD) else $error("no ud");
  wide_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_WIDE_VEC) && !sc_reg[XSE_SC_WIDE] |=> res_fault == XSE_FLT_UD)
    else $error("wide op not gated");
  user_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_wr && (op_cpl != 2'b00) |=> $stable(sc_reg)) else $error("user write took effect");
  exc_mask_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !simd_exc_en |=> !res_simd_exc) else $error("simd exception leaked");
  size_hdr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    fq_valid && leafd |=> fq_ecx >= XSE_LEGACY_AREA_BYTES + XSE_HEADER_BYTES) else $error("size lacks header");

  // =========================================
  // instruction outcome checks
  sequence op_taken_s;
    op_valid;
  endsequence
  sequence ud_answer_s;
    res_valid && (res_fault == XSE_FLT_UD);
  endsequence
  sequence ok_answer_s;
    res_valid && (res_fault == XSE_FLT_NONE);
  endsequence
  res_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_taken_s |=> res_valid)
    else $error("no result pulse");
  res_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !op_valid |=> !res_valid && (res_fault == XSE_FLT_NONE))
    else $error("result without request");
  rd_ud_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_rd && !os_mgmt |=> ud_answer_s ##0 (res_data == 64'h0000_0000_0000_0000))
    else $error("unmanaged read not faulted");
  wr_ud_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_wr && !os_mgmt |=> ud_answer_s)
    else $error("unmanaged write not faulted");
  wr_ud_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_wr && !os_mgmt |=> $stable(sc_reg))
    else $error("unmanaged write took effect");
  save_ud_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_SAVE_RESTORE) && !os_mgmt |=> ud_answer_s)
    else $error("unmanaged save not faulted");
  save_ok_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_SAVE_RESTORE) && os_mgmt |=> ok_answer_s)
    else $error("managed save faulted");
  bit0_gp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_wr && os_mgmt && !op_mask[XSE_SC_LEGACY_FP] |=> gp_answer_s)
    else $error("bit 0 clear not faulted");
  mask10_gp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_wr && os_mgmt && (op_mask[XSE_SC_WIDE:XSE_SC_NARROW] == 2'b10) |=> gp_answer_s)
    else $error("mask 10 not faulted");
  unsup_gp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_wr && os_mgmt && (|(op_mask & ~SUPPORT_VEC)) |=> gp_answer_s)
    else $error("unsupported bit not faulted");
  user_gp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_wr && os_mgmt && (op_cpl != 2'b00) |=> gp_answer_s)
    else $error("user write not faulted");
  wr_land_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    sc_wr_ok |=> (sc_reg == $past(op_mask)) && ok_answer_s)
    else $error("legal write lost");
  wr_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_wr && wr_gp |=> $stable(sc_reg))
    else $error("faulting write took effect");
  rd_data_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_rd && os_mgmt |=> ok_answer_s ##0 (res_data == $past(sc_reg)))
    else $error("read data wrong");
  rd_any_cpl_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    is_rd && os_mgmt && (op_cpl != 2'b00) |=> ok_answer_s)
    else $error("user read refused");

  // =========================================
  // vector and component gating checks
  wide_mgmt_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_WIDE_VEC) && !os_mgmt |=> ud_answer_s)
    else $error("wide op without management");
  wide_ok_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_WIDE_VEC) && wide_on |=> ok_answer_s)
    else $error("enabled wide op faulted");
  narrow_ud_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_NARROW_SIMD) && !leg_simd_en |=> ud_answer_s)
    else $error("narrow op not gated");
  narrow_ok_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_NARROW_SIMD) && leg_simd_en |=> ok_answer_s)
    else $error("narrow op faulted");
  low_comp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_EXT_STATE) && (op_comp <= 6'd1) |=> ok_answer_s)
    else $error("low component faulted");
  high_feat_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_EXT_STATE) && (op_comp > 6'd1) && !op_feat_ok |=> ud_answer_s)
    else $error("unsupported feature not faulted");
  high_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_EXT_STATE) && (op_comp > 6'd1) && !sc_reg[op_comp] |=> ud_answer_s)
    else $error("disabled component not faulted");
  high_mgmt_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_EXT_STATE) && (op_comp > 6'd1) && !os_mgmt |=> ud_answer_s)
    else $error("unmanaged component not faulted");
  exc_report_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    op_valid && (op_kind == XSE_OP_WIDE_VEC) && wide_on && op_simd_exc && simd_exc_en |=> res_simd_exc)
    else $error("simd exception lost");
  exc_valid_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    res_simd_exc |-> res_valid && (res_fault == XSE_FLT_NONE))
    else $error("simd exception without result");

  // =========================================
  // feature query and state checks
  save_sup_bit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    fq_valid && leaf1 |=> fq_ecx[XSE_L1_SAVE_SUP_BIT] == SAVE_SUPPORTED)
    else $error("support bit wrong");
  support_vec_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    fq_valid && leafd |=> {fq_edx, fq_eax} == SUPPORT_VEC)
    else $error("support vector wrong");
  size_exact_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    fq_valid && leafd |=> fq_ecx == (XSE_LEGACY_AREA_BYTES + XSE_HEADER_BYTES +
      ($past(sc_reg[XSE_SC_WIDE]) ? XSE_WIDE_AREA_BYTES : 32'h0000_0000)))
    else $error("save size wrong");
  fq_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    fq_valid |=> fq_done)
    else $error("no query answer");
  fq_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !fq_valid |=> !fq_done && (fq_eax == 32'h0000_0000) && (fq_ecx == 32'h0000_0000))
    else $error("query answer without request");
  no_unsup_mgmt_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (SAVE_SUPPORTED == 1'b1) || !os_mgmt)
    else $error("management set without support");
  sc_mirror_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    sc_enable == sc_reg)
    else $error("enable output differs");
  cr4_mirror_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    cr4_rdata == cr4_reg)
    else $error("control readback differs");
  rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sc_reg & ~SUPPORT_VEC) == 64'h0000_0000_0000_0000)
    else $error("unsupported component enabled");
endmodule : xse_gate

// ===== verification/xse_sw_model.sv
// software side model: enable mask that well-behaved system code writes
`timescale 1ns/1ps
module xse_sw_model (
  output logic [63:0] legal_mask
);
  // =====================================
  // legal mask: bit 0 kept, [2:1] = 11, 63:3 zero, reported support
  assign legal_mask = 64'h0000_0000_0000_0007;
endmodule : xse_sw_model

// ===== verification/tb_xse_gate.sv
// testbench for extended state enable gating
`timescale 1ns/1ps
module tb_xse_gate
  import xse_pkg::*;
;
  logic core_clk = 0, rst_b = 0, cr4_wr = 0, op_valid = 0, op_feat_ok = 0, op_simd_exc = 0, fq_valid = 0;
  logic [31:0] cr4_wdata = 0, fq_leaf = 0, fq_sub = 0, cr4_rdata, fq_eax, fq_ecx, fq_edx;
  xse_op_t op_kind = XSE_OP_NONE;
  logic [1:0] op_cpl = 0;
  logic [63:0] op_mask = 0, res_data, sc_enable, legal_mask;
  logic [5:0] op_comp = 6'h02;
  logic res_valid, res_simd_exc, fq_done;
  xse_fault_t res_fault;
  int error_cnt = 0, check_count = 0;
  xse_gate u_dut (.core_clk, .rst_b, .cr4_wr, .cr4_wdata, .cr4_rdata, .op_valid, .op_kind, .op_cpl, .op_mask,
    .op_comp, .op_feat_ok, .op_simd_exc, .res_valid, .res_fault, .res_data, .res_simd_exc, .fq_valid, .fq_leaf,
    .fq_sub, .fq_done, .fq_eax, .fq_ecx, .fq_edx, .sc_enable);
  xse_sw_model u_sw (.legal_mask);
  // =====================================
  // shared tasks
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cr4(logic [31:0] d);
    @(negedge core_clk) cr4_wr = 1;
    cr4_wdata = d;
    @(negedge core_clk) cr4_wr = 0;
  endtask : cr4
  task automatic op(xse_op_t k, logic [1:0] c, logic [63:0] m, logic f, logic x);
    @(negedge core_clk) op_valid = 1;
    op_kind = k;
    op_cpl = c;
    op_mask = m;
    op_feat_ok = f;
    op_simd_exc = x;
    @(negedge core_clk) op_valid = 0;
    chk("res_valid", 1, res_valid);
  endtask : op
  task automatic fq(logic [31:0] l);
    @(negedge core_clk) fq_valid = 1;
    fq_leaf = l;
    @(negedge core_clk) fq_valid = 0;
    chk("fq_done", 1, fq_done);
  endtask : fq
  task automatic complete_run;
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // =====================================
  // scenarios
  task automatic t_unmanaged;
    chk("sc_enable", 64'h1, sc_enable);
    fq(32'h1);
    chk("leaf1 ecx", 64'h0400_0000, fq_ecx);
    op(XSE_OP_WRITE_EN, 0, 64'h7, 1, 0);
    chk("fault", XSE_FLT_UD, res_fault);
    op(XSE_OP_SAVE_RESTORE, 0, 64'h7, 1, 0);
    chk("fault", XSE_FLT_UD, res_fault);
  endtask : t_unmanaged
  task automatic t_bad_writes;
    cr4(32'h0004_0200);
    chk("cr4_rdata", 64'h0004_0200, cr4_rdata);
    fq(32'h1);
    chk("leaf1 ecx", 64'h0c00_0000, fq_ecx);
    op(XSE_OP_WRITE_EN, 1, legal_mask, 1, 0);
    chk("fault", XSE_FLT_GP, res_fault);
    op(XSE_OP_WRITE_EN, 0, 64'h6, 1, 0);
    chk("fault", XSE_FLT_GP, res_fault);
    op(XSE_OP_WRITE_EN, 0, 64'h5, 1, 0);
    chk("fault", XSE_FLT_GP, res_fault);
    op(XSE_OP_WRITE_EN, 0, 64'h9, 1, 0);
    chk("fault", XSE_FLT_GP, res_fault);
    chk("sc_enable", 64'h1, sc_enable);
    op(XSE_OP_WIDE_VEC, 0, 0, 1, 0);
    chk("fault", XSE_FLT_UD, res_fault);
    op(XSE_OP_EXT_STATE, 3, 0, 1, 0);
    chk("fault", XSE_FLT_UD, res_fault);
  endtask : t_bad_writes
  task automatic t_enable_wide;
    op(XSE_OP_WRITE_EN, 0, legal_mask, 1, 0);
    chk("fault", XSE_FLT_NONE, res_fault);
    chk("sc_enable", 64'h7, sc_enable);
    op(XSE_OP_READ_EN, 3, 0, 1, 0);
    chk("read data", 64'h7, res_data);
    fq(32'hd);
    chk("support", 64'h7, {fq_edx, fq_eax});
    chk("size", 64'h340, fq_ecx);
    op(XSE_OP_EXT_STATE, 3, 0, 0, 0);
    chk("fault", XSE_FLT_UD, res_fault);
    op(XSE_OP_EXT_STATE, 3, 0, 1, 0);
    chk("fault", XSE_FLT_NONE, res_fault);
  endtask : t_enable_wide
  task automatic t_simd;
    op(XSE_OP_WIDE_VEC, 3, 0, 1, 1);
    chk("simd exc", 0, res_simd_exc);
    cr4(32'h0004_0400);
    chk("cr4_rdata", 64'h0004_0400, cr4_rdata);
    op(XSE_OP_WIDE_VEC, 3, 0, 1, 1);
    chk("fault", XSE_FLT_NONE, res_fault);
    chk("simd exc", 1, res_simd_exc);
    op(XSE_OP_NARROW_SIMD, 3, 0, 1, 0);
    chk("fault", XSE_FLT_UD, res_fault);
    cr4(32'h0000_0200);
    op(XSE_OP_NARROW_SIMD, 3, 0, 1, 0);
    chk("fault", XSE_FLT_NONE, res_fault);
  endtask : t_simd
  initial begin
    repeat (4) @(negedge core_clk);
    rst_b = 1;
    t_unmanaged();
    t_bad_writes();
    t_enable_wide();
    t_simd();
    complete_run();
  end
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
endmodule : tb_xse_gate
